// >>> rtl/idr_pkg.sv
// idr_pkg: constants for the input divider, rate band and active input status bank
// assumes: byte-wide register port with 8-bit addresses, one 10 MHz clock domain
`default_nettype none

package idr_pkg;

    // ****************************************************************
    // widths
    // ****************************************************************
    localparam int unsigned IDR_ADDR_W    = 8;
    localparam int unsigned IDR_DATA_W    = 8;
    localparam int unsigned IDR_DIV_W     = 19;
    localparam int unsigned IDR_BAND_W    = 3;
    localparam int unsigned IDR_NUM_IN    = 4;
    localparam int unsigned IDR_SYNC_LEN  = 2;

    // ****************************************************************
    // register offsets
    // ****************************************************************
    localparam logic [7:0] IDR_ADDR_DIV_UPPER  = 8'h34;
    localparam logic [7:0] IDR_ADDR_DIV_MIDDLE = 8'h35;
    localparam logic [7:0] IDR_ADDR_DIV_LOWER  = 8'h36;
    localparam logic [7:0] IDR_ADDR_BAND_12    = 8'h37;
    localparam logic [7:0] IDR_ADDR_BAND_34    = 8'h38;
    localparam logic [7:0] IDR_ADDR_ACTIVE     = 8'h80;

    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int unsigned IDR_DIV_UPPER_LSB  = 16;
    localparam int unsigned IDR_DIV_UPPER_MSB  = 18;
    localparam int unsigned IDR_DIV_MIDDLE_LSB = 8;
    localparam int unsigned IDR_DIV_MIDDLE_MSB = 15;
    localparam int unsigned IDR_DIV_LOWER_LSB  = 0;
    localparam int unsigned IDR_DIV_LOWER_MSB  = 7;
    localparam int unsigned IDR_UPPER_FLD_MSB  = 2;
    localparam int unsigned IDR_BAND_ODD_LSB   = 0;
    localparam int unsigned IDR_BAND_ODD_MSB   = 2;
    localparam int unsigned IDR_BAND_EVEN_LSB  = 3;
    localparam int unsigned IDR_BAND_EVEN_MSB  = 5;
    localparam int unsigned IDR_ACTIVE_MSB     = 3;

    // ****************************************************************
    // reset values
    // ****************************************************************
    localparam logic [7:0] IDR_RST_DIV_UPPER  = 8'h00;
    localparam logic [7:0] IDR_RST_DIV_MIDDLE = 8'h00;
    localparam logic [7:0] IDR_RST_DIV_LOWER  = 8'h09;
    localparam logic [2:0] IDR_RST_BAND       = 3'h0;
    localparam logic [7:0] IDR_RD_ZERO        = 8'h00;
    localparam logic [3:0] IDR_FLAGS_ZERO     = 4'h0;

    // ****************************************************************
    // band codes
    // ****************************************************************
    localparam logic [2:0] IDR_BAND_10_27    = 3'h0;
    localparam logic [2:0] IDR_BAND_25_54    = 3'h1;
    localparam logic [2:0] IDR_BAND_50_105   = 3'h2;
    localparam logic [2:0] IDR_BAND_95_215   = 3'h3;
    localparam logic [2:0] IDR_BAND_190_435  = 3'h4;
    localparam logic [2:0] IDR_BAND_375_710  = 3'h5;
    localparam logic [2:0] IDR_BAND_LAST_OK  = IDR_BAND_375_710;

endpackage : idr_pkg

`default_nettype wire

// >>> rtl/idr_sync.sv
// idr_sync: two-stage level synchroniser, one per bit, frozen with the clock enable
// assumes: inputs are quasi-static levels from outside the mclk_in domain
`timescale 1ns/100ps
`default_nettype none

module idr_sync
    import idr_pkg::*;
#(
    parameter int unsigned WIDTH = 1
)
(
    input  wire logic             mclk_in,
    input  wire logic             rst_n_in,
    input  wire logic             ce_in,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] meta_next;
    logic [WIDTH-1:0] sync_reg;
    logic [WIDTH-1:0] sync_next;

    // first stage feeds only the second stage
    always_comb
    begin
        meta_next = meta_reg;
        sync_next = sync_reg;
        if (ce_in)
        begin
            meta_next = async_in;
            sync_next = meta_reg;
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            meta_reg <= '0;
            sync_reg <= '0;
        end
        else
        begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
        end
    end

    assign sync_out = sync_reg;

endmodule : idr_sync

`default_nettype wire

// >>> rtl/idr_regs.sv
// idr_regs: fourth input divider, four rate band codes and the active input status byte
// assumes: the serial port decoder on mclk_in presents single-cycle write and read strobes;
//          reference selection and loss-of-signal levels arrive from other clock domains
`timescale 1ns/100ps
`default_nettype none

// Function
// - 19-bit fourth input divider across three bytes
// - upper divider byte resets to all zeros
// - lower divider byte resets to 0x09
// - 3-bit band code per input, 6-7 reserved
// - two codes per byte, odd low, even high
// - status bits 3..0 flag inputs four..one active
// - flag clear if unselected or signal lost
// - status upper bits reserved, writes have no effect
// - loss indication 0 normal, 1 on alarm
module idr_regs
    import idr_pkg::*;
(
    input  wire logic                  mclk_in,
    input  wire logic                  rst_n_in,
    input  wire logic                  ce_in,
    input  wire logic [IDR_ADDR_W-1:0] reg_addr_in,
    input  wire logic                  reg_wr_in,
    input  wire logic [IDR_DATA_W-1:0] reg_wdata_in,
    input  wire logic                  reg_rd_in,
    output logic      [IDR_DATA_W-1:0] reg_rdata_out,
    output logic                       reg_rvalid_out,
    input  wire logic [IDR_NUM_IN-1:0] ref_select_in,
    input  wire logic [IDR_NUM_IN-1:0] signal_loss_in,
    output logic      [IDR_DIV_W-1:0]  fourth_input_divider_out,
    output logic      [IDR_BAND_W-1:0] first_input_band_code_out,
    output logic      [IDR_BAND_W-1:0] second_input_band_code_out,
    output logic      [IDR_BAND_W-1:0] third_input_band_code_out,
    output logic      [IDR_BAND_W-1:0] fourth_input_band_code_out,
    output logic      [IDR_NUM_IN-1:0] active_flags_out
);

    // ****************************************************************
    // synchronised status inputs
    // ****************************************************************
    logic [IDR_NUM_IN-1:0] ref_select_sync;
    logic [IDR_NUM_IN-1:0] signal_loss_sync;

    // selection and loss come from the pll side, so both pass two flops first
    idr_sync #(
        .WIDTH (IDR_NUM_IN)
    ) u_sel_sync (
        .mclk_in  (mclk_in),
        .rst_n_in (rst_n_in),
        .ce_in    (ce_in),
        .async_in (ref_select_in),
        .sync_out (ref_select_sync)
    );

    idr_sync #(
        .WIDTH (IDR_NUM_IN)
    ) u_loss_sync (
        .mclk_in  (mclk_in),
        .rst_n_in (rst_n_in),
        .ce_in    (ce_in),
        .async_in (signal_loss_in),
        .sync_out (signal_loss_sync)
    );

    // ****************************************************************
    // register state
    // ****************************************************************
    logic [IDR_UPPER_FLD_MSB:0] div_upper_reg;
    logic [IDR_UPPER_FLD_MSB:0] div_upper_next;
    logic [IDR_DATA_W-1:0]      div_middle_reg;
    logic [IDR_DATA_W-1:0]      div_middle_next;
    logic [IDR_DATA_W-1:0]      div_lower_reg;
    logic [IDR_DATA_W-1:0]      div_lower_next;
    logic [IDR_BAND_W-1:0]      band1_reg;
    logic [IDR_BAND_W-1:0]      band1_next;
    logic [IDR_BAND_W-1:0]      band2_reg;
    logic [IDR_BAND_W-1:0]      band2_next;
    logic [IDR_BAND_W-1:0]      band3_reg;
    logic [IDR_BAND_W-1:0]      band3_next;
    logic [IDR_BAND_W-1:0]      band4_reg;
    logic [IDR_BAND_W-1:0]      band4_next;
    logic [IDR_NUM_IN-1:0]      active_reg;
    logic [IDR_NUM_IN-1:0]      active_next;
    logic [IDR_DATA_W-1:0]      rdata_reg;
    logic [IDR_DATA_W-1:0]      rdata_next;
    logic                       rvalid_reg;
    logic                       rvalid_next;

    logic [IDR_BAND_W-1:0]      wr_band_odd;
    logic [IDR_BAND_W-1:0]      wr_band_even;
    logic                       wr_odd_ok;
    logic                       wr_even_ok;

    // reserved codes are refused per field; the field keeps its last legal code
    assign wr_band_odd  = reg_wdata_in[IDR_BAND_ODD_MSB:IDR_BAND_ODD_LSB];
    assign wr_band_even = reg_wdata_in[IDR_BAND_EVEN_MSB:IDR_BAND_EVEN_LSB];
    assign wr_odd_ok    = (wr_band_odd <= IDR_BAND_LAST_OK);
    assign wr_even_ok   = (wr_band_even <= IDR_BAND_LAST_OK);

    // ****************************************************************
    // address decode
    // ****************************************************************
    // write and read share one decode so the two maps cannot drift apart
    logic                       hit_div_upper;
    logic                       hit_div_middle;
    logic                       hit_div_lower;
    logic                       hit_band_12;
    logic                       hit_band_34;
    logic                       hit_active;

    always_comb
    begin
        hit_div_upper  = 1'b0;
        hit_div_middle = 1'b0;
        hit_div_lower  = 1'b0;
        hit_band_12    = 1'b0;
        hit_band_34    = 1'b0;
        hit_active     = 1'b0;
        if (reg_addr_in == IDR_ADDR_DIV_UPPER)
        begin
            hit_div_upper = 1'b1;
        end
        else if (reg_addr_in == IDR_ADDR_DIV_MIDDLE)
        begin
            hit_div_middle = 1'b1;
        end
        else if (reg_addr_in == IDR_ADDR_DIV_LOWER)
        begin
            hit_div_lower = 1'b1;
        end
        else if (reg_addr_in == IDR_ADDR_BAND_12)
        begin
            hit_band_12 = 1'b1;
        end
        else if (reg_addr_in == IDR_ADDR_BAND_34)
        begin
            hit_band_34 = 1'b1;
        end
        else if (reg_addr_in == IDR_ADDR_ACTIVE)
        begin
            hit_active = 1'b1;
        end
    end

    // ****************************************************************
    // write decode
    // ****************************************************************
    always_comb
    begin
        div_upper_next  = div_upper_reg;
        div_middle_next = div_middle_reg;
        div_lower_next  = div_lower_reg;
        band1_next      = band1_reg;
        band2_next      = band2_reg;
        band3_next      = band3_reg;
        band4_next      = band4_reg;
        if (ce_in && reg_wr_in)
        begin
            if (hit_div_upper)
            begin
                // only bits 2:0 are stored; bits 7:3 are dropped
                div_upper_next = reg_wdata_in[IDR_UPPER_FLD_MSB:0];
            end
            else if (hit_div_middle)
            begin
                div_middle_next = reg_wdata_in;
            end
            else if (hit_div_lower)
            begin
                div_lower_next = reg_wdata_in;
            end
            else if (hit_band_12)
            begin
                if (wr_odd_ok)
                begin
                    band1_next = wr_band_odd;
                end
                if (wr_even_ok)
                begin
                    band2_next = wr_band_even;
                end
            end
            else if (hit_band_34)
            begin
                if (wr_odd_ok)
                begin
                    band3_next = wr_band_odd;
                end
                if (wr_even_ok)
                begin
                    band4_next = wr_band_even;
                end
            end
            // the status byte and unmapped offsets take no write
        end
    end

    // ****************************************************************
    // active input status
    // ****************************************************************
    always_comb
    begin
        active_next = active_reg;
        if (ce_in)
        begin
            // a lost input never shows active, even while still selected
            active_next = ref_select_sync & ~signal_loss_sync;
        end
    end

    // ****************************************************************
    // read path
    // ****************************************************************
    always_comb
    begin
        rdata_next  = rdata_reg;
        rvalid_next = rvalid_reg;
        if (ce_in)
        begin
            rvalid_next = reg_rd_in;
            if (reg_rd_in)
            begin
                rdata_next = IDR_RD_ZERO;
                if (hit_div_upper)
                begin
                    rdata_next[IDR_UPPER_FLD_MSB:0] = div_upper_reg;
                end
                else if (hit_div_middle)
                begin
                    rdata_next = div_middle_reg;
                end
                else if (hit_div_lower)
                begin
                    rdata_next = div_lower_reg;
                end
                else if (hit_band_12)
                begin
                    rdata_next[IDR_BAND_ODD_MSB:IDR_BAND_ODD_LSB]   = band1_reg;
                    rdata_next[IDR_BAND_EVEN_MSB:IDR_BAND_EVEN_LSB] = band2_reg;
                end
                else if (hit_band_34)
                begin
                    rdata_next[IDR_BAND_ODD_MSB:IDR_BAND_ODD_LSB]   = band3_reg;
                    rdata_next[IDR_BAND_EVEN_MSB:IDR_BAND_EVEN_LSB] = band4_reg;
                end
                else if (hit_active)
                begin
                    rdata_next[IDR_ACTIVE_MSB:0] = active_reg;
                end
            end
        end
    end

    // ****************************************************************
    // registers
    // ****************************************************************
    always_ff @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            div_upper_reg  <= IDR_RST_DIV_UPPER[IDR_UPPER_FLD_MSB:0];
            div_middle_reg <= IDR_RST_DIV_MIDDLE;
            div_lower_reg  <= IDR_RST_DIV_LOWER;
            band1_reg      <= IDR_RST_BAND;
            band2_reg      <= IDR_RST_BAND;
            band3_reg      <= IDR_RST_BAND;
            band4_reg      <= IDR_RST_BAND;
            active_reg     <= IDR_FLAGS_ZERO;
            rdata_reg      <= IDR_RD_ZERO;
            rvalid_reg     <= 1'b0;
        end
        else
        begin
            div_upper_reg  <= div_upper_next;
            div_middle_reg <= div_middle_next;
            div_lower_reg  <= div_lower_next;
            band1_reg      <= band1_next;
            band2_reg      <= band2_next;
            band3_reg      <= band3_next;
            band4_reg      <= band4_next;
            active_reg     <= active_next;
            rdata_reg      <= rdata_next;
            rvalid_reg     <= rvalid_next;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    // zero divider means divide by one; the divider logic downstream decodes that
    assign fourth_input_divider_out   = {div_upper_reg, div_middle_reg, div_lower_reg};
    assign first_input_band_code_out  = band1_reg;
    assign second_input_band_code_out = band2_reg;
    assign third_input_band_code_out  = band3_reg;
    assign fourth_input_band_code_out = band4_reg;
    assign active_flags_out           = active_reg;
    assign reg_rdata_out              = rdata_reg;
    assign reg_rvalid_out             = rvalid_reg;

endmodule : idr_regs

`default_nettype wire

// >>> bench/idr_regs_assertions.sv
// idr_regs_assertions: port-level checks of the divider, band and status bank
// assumes: bound into idr_regs, single mclk_in domain
`timescale 1ns/100ps
`default_nettype none

module idr_regs_assertions
    import idr_pkg::*;
(
    input wire logic        mclk_in,
    input wire logic        rst_n_in,
    input wire logic        ce_in,
    input wire logic [7:0]  reg_addr_in,
    input wire logic        reg_wr_in,
    input wire logic [7:0]  reg_wdata_in,
    input wire logic        reg_rd_in,
    input wire logic [7:0]  reg_rdata_out,
    input wire logic        reg_rvalid_out,
    input wire logic [3:0]  ref_select_in,
    input wire logic [3:0]  signal_loss_in,
    input wire logic [18:0] fourth_input_divider_out,
    input wire logic [2:0]  first_input_band_code_out,
    input wire logic [2:0]  second_input_band_code_out,
    input wire logic [2:0]  third_input_band_code_out,
    input wire logic [2:0]  fourth_input_band_code_out,
    input wire logic [3:0]  active_flags_out
);
    // ****************************************
    // consecutive enabled edges, saturating at the sync depth plus one
    // ****************************************
    logic [1:0] ce_cnt_reg;
    logic [1:0] ce_cnt_next;
    logic       wr_ok;
    logic       rd_ok;

    assign wr_ok = ce_in && reg_wr_in;
    assign rd_ok = ce_in && reg_rd_in;

    always_comb
    begin
        ce_cnt_next = !ce_in ? 2'h0 : (ce_cnt_reg == 2'h3) ? 2'h3 : ce_cnt_reg + 2'h1;
    end

    always_ff @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            ce_cnt_reg <= 2'h0;
        else
            ce_cnt_reg <= ce_cnt_next;
    end

    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);

    a_div_upper_write: assert property (
        wr_ok && reg_addr_in == 8'h34 |=> fourth_input_divider_out[18:16] == $past(reg_wdata_in[2:0]))
        else $error("upper divider bits not taken from write");
    a_div_middle_write: assert property (
        wr_ok && reg_addr_in == 8'h35 |=> fourth_input_divider_out[15:8] == $past(reg_wdata_in))
        else $error("middle divider byte not taken from write");
    a_div_holds_value: assert property (
        !(wr_ok && reg_addr_in inside {8'h34, 8'h35, 8'h36}) |=> $stable(fourth_input_divider_out))
        else $error("divider changed without a divider write");
    a_band_odd_write: assert property (
        wr_ok && reg_addr_in == 8'h37 && reg_wdata_in[2:0] <= 3'h5
        |=> first_input_band_code_out == $past(reg_wdata_in[2:0]))
        else $error("first band code not taken from bits 2:0");
    a_band_reserved_kept: assert property (
        wr_ok && reg_addr_in == 8'h38 && reg_wdata_in[5:3] > 3'h5 |=> $stable(fourth_input_band_code_out))
        else $error("reserved band code accepted");
    a_band_read_back: assert property (
        rd_ok && reg_addr_in == 8'h38
        |=> reg_rdata_out == {2'h0, $past(fourth_input_band_code_out), $past(third_input_band_code_out)})
        else $error("band byte read mismatch");
    a_rvalid_one_cycle: assert property (
        ce_in |=> reg_rvalid_out == $past(reg_rd_in))
        else $error("read valid not one cycle after read strobe");
    a_status_read_back: assert property (
        rd_ok && reg_addr_in == 8'h80 |=> reg_rdata_out == {4'h0, $past(active_flags_out)})
        else $error("status byte read mismatch");
    a_flags_follow_inputs: assert property (
        ce_cnt_reg == 2'h3 |-> active_flags_out == ($past(ref_select_in, 3) & ~$past(signal_loss_in, 3)))
        else $error("active flags do not follow selection and loss");

    c_reserved_band: cover property (wr_ok && reg_addr_in == 8'h38 && reg_wdata_in[5:3] > 3'h5);
    c_flag_active: cover property (active_flags_out != 4'h0);
    c_status_read: cover property (rd_ok && reg_addr_in == 8'h80);
endmodule : idr_regs_assertions

bind idr_regs idr_regs_assertions u_chk (.mclk_in, .rst_n_in, .ce_in, .reg_addr_in, .reg_wr_in,
    .reg_wdata_in, .reg_rd_in, .reg_rdata_out, .reg_rvalid_out, .ref_select_in, .signal_loss_in,
    .fourth_input_divider_out, .first_input_band_code_out, .second_input_band_code_out,
    .third_input_band_code_out, .fourth_input_band_code_out, .active_flags_out);

`default_nettype wire

// >>> bench/test_input_divider_rate_status_regs.sv
// test_input_divider_rate_status_regs: directed bench for the register bank
// assumes: idr_regs alone, driven 1 ns after each rising edge
`timescale 1ns/100ps
`default_nettype none

module test_input_divider_rate_status_regs
    import idr_pkg::*;
;
    logic        mclk_in;
    logic        rst_n_in;
    logic        ce_in;
    logic [7:0]  reg_addr_in;
    logic        reg_wr_in;
    logic [7:0]  reg_wdata_in;
    logic        reg_rd_in;
    logic [7:0]  reg_rdata_out;
    logic        reg_rvalid_out;
    logic [3:0]  ref_select_in;
    logic [3:0]  signal_loss_in;
    logic [18:0] div_out;
    logic [2:0]  b1;
    logic [2:0]  b2;
    logic [2:0]  b3;
    logic [2:0]  b4;
    logic [3:0]  flags;
    int          errors;
    int          checks_done;
    int          cycles;

    idr_regs DUT (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .ce_in(ce_in), .reg_addr_in(reg_addr_in),
        .reg_wr_in(reg_wr_in), .reg_wdata_in(reg_wdata_in), .reg_rd_in(reg_rd_in),
        .reg_rdata_out(reg_rdata_out), .reg_rvalid_out(reg_rvalid_out), .ref_select_in(ref_select_in),
        .signal_loss_in(signal_loss_in), .fourth_input_divider_out(div_out),
        .first_input_band_code_out(b1), .second_input_band_code_out(b2),
        .third_input_band_code_out(b3), .fourth_input_band_code_out(b4), .active_flags_out(flags));

    // ****************************************
    // clock, timeout and shared tasks
    // ****************************************
    initial
    begin
        mclk_in = 1'b0;
        forever #50 mclk_in = ~mclk_in;
    end

    // whole run needs about 125 cycles
    always @(posedge mclk_in)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            errors++;
            report_and_stop();
        end
    end

    task automatic chk(input string what, input logic [18:0] exp, input logic [18:0] got);
        checks_done++;
        if (got !== exp)
        begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_in);
        #1;
        reg_addr_in = a;
        reg_wdata_in = d;
        reg_wr_in = 1'b1;
        @(posedge mclk_in);
        #1;
        reg_wr_in = 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge mclk_in);
        #1;
        reg_addr_in = a;
        reg_rd_in = 1'b1;
        @(posedge mclk_in);
        #1;
        reg_rd_in = 1'b0;
        chk("read valid", 19'h1, {18'h0, reg_rvalid_out});
        chk($sformatf("read %h", a), {11'h0, exp}, {11'h0, reg_rdata_out});
    endtask : rd

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset();
        rd(IDR_ADDR_DIV_UPPER, 8'h00);
        rd(IDR_ADDR_DIV_LOWER, 8'h09);
        chk("divider", 19'h00009, div_out);
        rd(IDR_ADDR_ACTIVE, 8'h00);
        $display("reset values done");
    endtask : t_reset

    task automatic t_divider();
        wr(IDR_ADDR_DIV_UPPER, 8'hFF);
        wr(IDR_ADDR_DIV_MIDDLE, 8'hA5);
        wr(IDR_ADDR_DIV_LOWER, 8'h00);
        chk("divider", 19'h7A500, div_out);
        rd(IDR_ADDR_DIV_UPPER, 8'h07);
        rd(IDR_ADDR_DIV_MIDDLE, 8'hA5);
        rd(IDR_ADDR_DIV_LOWER, 8'h00);
        $display("divider done");
    endtask : t_divider

    // strobes while the enable is low are lost; the frozen flops keep the last divider and read data
    task automatic t_freeze();
        ce_in = 1'b0;
        wr(IDR_ADDR_DIV_MIDDLE, 8'h3C);
        chk("frozen divider", 19'h7A500, div_out);
        reg_rd_in = 1'b1;
        @(posedge mclk_in);
        #1;
        reg_rd_in = 1'b0;
        chk("frozen read data", 19'h0, {11'h0, reg_rdata_out});
        ce_in = 1'b1;
        $display("clock enable done");
    endtask : t_freeze

    // both fields of a byte get different codes so a swap or a whole-byte refusal shows
    task automatic t_bands();
        logic [2:0] c;
        logic [2:0] e;
        logic [2:0] xc;
        logic [2:0] xe;
        xc = 3'h0;
        xe = 3'h0;
        for (int i = 0; i < 8; i++)
        begin
            c = 3'(i);
            e = c + 3'h2;
            if (c <= 3'h5)
                xc = c;
            if (e <= 3'h5)
                xe = e;
            wr(IDR_ADDR_BAND_12, {2'b11, e, c});
            wr(IDR_ADDR_BAND_34, {2'b11, c, e});
            rd(IDR_ADDR_BAND_12, {2'h0, xe, xc});
            rd(IDR_ADDR_BAND_34, {2'h0, xc, xe});
            chk("band codes", {7'h0, xc, xe, xe, xc}, {7'h0, b1, b2, b3, b4});
        end
        $display("band codes done");
    endtask : t_bands

    task automatic t_status();
        logic [3:0] sel;
        wr(IDR_ADDR_ACTIVE, 8'hFF);
        rd(IDR_ADDR_ACTIVE, 8'h00);
        for (int i = 0; i < 4; i++)
        begin
            sel = 4'(1 << i);
            ref_select_in = sel;
            signal_loss_in = ~sel;
            repeat (3) @(posedge mclk_in);
            #1;
            chk("flags selected", {15'h0, sel}, {15'h0, flags});
            rd(IDR_ADDR_ACTIVE, {4'h0, sel});
            signal_loss_in = sel;
            repeat (3) @(posedge mclk_in);
            #1;
            chk("flags lost", 19'h0, {15'h0, flags});
        end
        $display("active status done");
    endtask : t_status

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : report_and_stop

    initial
    begin
        rst_n_in = 1'b0;
        ce_in = 1'b1;
        reg_addr_in = 8'h00;
        reg_wr_in = 1'b0;
        reg_wdata_in = 8'h00;
        reg_rd_in = 1'b0;
        ref_select_in = 4'h0;
        signal_loss_in = 4'h0;
        repeat (3) @(posedge mclk_in);
        #1;
        rst_n_in = 1'b1;
        t_reset();
        t_divider();
        t_freeze();
        t_bands();
        t_status();
        report_and_stop();
    end
endmodule : test_input_divider_rate_status_regs

`default_nettype wire
